// file: verilog/wdk_top.sv
// Watchdog timer key and mode control with APB register access
//
// Chosen here: the address map and the APB register port.
`default_nettype none

// Function
// - Second mode register write after reset forces overflow and clears counter
// - Key register write of any value except ACH forces overflow at once
// - No forced overflow from mode rewrite or bad key while stopped
// - First write of 1FH to mode register after reset stops the watchdog unless locked
// - With lock bit set, stop attempts are ignored; only reset halts it
// - With lock bit set, clock forced to internal oscillator, 2^12 to 2^19
// - Single-bit write to key register counts as bad key, forces overflow
// - Key register always reads 9AH
// - Watchdog counts from reset release in reset-on-overflow mode
// - Mode default is reset-on-overflow with 2^19 oscillator periods
// - With lock bit set, overflow action fixed to reset mode
// - Outside reset mode an overflow raises a non-maskable interrupt
module wdk_top #(
  parameter int OSC_DIV = wdk_pkg::OSC_DIV_DEF
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [wdk_pkg::ADDR_W-1:0] paddr,
  input  wire logic [wdk_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [wdk_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       option_lock_bit,
  output logic                            wdt_overflow_nmi,
  output logic                            wdt_reset_req,
  output logic                            irq
);

  import wdk_pkg::*;

  localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

  // Internal oscillator tick divider
  logic [DIV_W-1:0]  osc_cnt_r;
  logic              internal_osc_clock;

  // Option lock capture
  logic              lock_r;
  logic              lock_seen_r;

  // Bus handshake
  logic              pready_r;
  logic              pslverr_r;
  logic [DATA_W-1:0] prdata_r;
  logic              acc;
  logic              wr_acc;
  logic              lane0;

  // Address decode
  logic              hit_mode;
  logic              hit_key;
  logic              hit_keybit;
  logic              hit_stat;
  logic              hit_mask;
  logic              hit_cnt;
  logic              hit_any;

  // Mode state
  logic [REG_W-1:0]  wdt_mode_reg_r;
  logic              mode_written_r;
  logic              stopped_r;

  // Effective configuration
  logic              src_core;
  logic              rst_mode;
  logic [SEL_W-1:0]  sel_eff;
  logic              cnt_tick;

  // Events
  logic              key_ok;
  logic              forced;
  logic              cnt_ovf;
  logic              ovf_evt;
  logic [CNT_W-1:0]  cnt_val;

  // Outputs and interrupt state
  logic              nmi_r;
  logic              rstreq_r;
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] stat_nxt;
  logic [STAT_W-1:0] mask_r;
  logic [STAT_W-1:0] stat_set;
  logic              irq_r;

  // Divider producing the internal oscillator count enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_r <= '0;
    end else if (osc_cnt_r == DIV_LAST) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_cnt_r + 1'b1;
    end
  end

  // One-cycle tick on the divider wrap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      internal_osc_clock <= 1'b0;
    end else begin
      internal_osc_clock <= (osc_cnt_r == DIV_LAST);
    end
  end

  // Lock strap caught once after reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_r <= 1'b0;
    end else if (!lock_seen_r) begin
      lock_r <= option_lock_bit;
    end
  end

  // Marks that the strap has been taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_seen_r <= 1'b0;
    end else begin
      lock_seen_r <= 1'b1;
    end
  end

  // One wait state: pready rises in the second access cycle
  assign acc    = psel & penable & pready_r;
  assign wr_acc = acc & pwrite;
  assign lane0  = pstrb[0];

  // Offset decode
  always_comb begin
    hit_mode   = 1'b0;
    hit_key    = 1'b0;
    hit_keybit = 1'b0;
    hit_stat   = 1'b0;
    hit_mask   = 1'b0;
    hit_cnt    = 1'b0;
    if (paddr == OFS_MODE) begin
      hit_mode = 1'b1;
    end else if (paddr == OFS_KEY) begin
      hit_key = 1'b1;
    end else if (paddr == OFS_KEYBIT) begin
      hit_keybit = 1'b1;
    end else if (paddr == OFS_STAT) begin
      hit_stat = 1'b1;
    end else if (paddr == OFS_MASK) begin
      hit_mask = 1'b1;
    end else if (paddr == OFS_CNT) begin
      hit_cnt = 1'b1;
    end
  end

  // Any mapped offset
  assign hit_any = hit_mode | hit_key | hit_keybit | hit_stat | hit_mask | hit_cnt;

  // One access cycle of wait before pready
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
    end
  end

  // Slave error for unmapped offsets, given with pready
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= psel & penable & ~pready_r & ~hit_any;
    end
  end

  // Read data prepared one cycle ahead of pready
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= '0;
    end else if (psel && penable && !pready_r && !pwrite) begin
      if (hit_mode) begin
        prdata_r <= DATA_W'(wdt_mode_reg_r);
      end else if (hit_key || hit_keybit) begin
        prdata_r <= DATA_W'(KEY_READ);
      end else if (hit_stat) begin
        prdata_r <= DATA_W'(stat_r);
      end else if (hit_mask) begin
        prdata_r <= DATA_W'(mask_r);
      end else if (hit_cnt) begin
        prdata_r <= DATA_W'(cnt_val);
      end else begin
        prdata_r <= '0;
      end
    end
  end

  // Mode register: first write takes, later ones only force
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_mode_reg_r <= MODE_RST_VAL;
    end else if (wr_acc && hit_mode && lane0 && !mode_written_r) begin
      wdt_mode_reg_r <= pwdata[REG_W-1:0] & MODE_WR_MASK;
    end
  end

  // Any accepted mode write arms the rewrite overflow
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_written_r <= 1'b0;
    end else if (wr_acc && hit_mode && lane0) begin
      mode_written_r <= 1'b1;
    end
  end

  // Stop request honoured only when unlocked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stopped_r <= 1'b0;
    end else if (wr_acc && hit_mode && lane0 && !mode_written_r) begin
      stopped_r <= (pwdata[REG_W-1:0] == MODE_STOP) & ~lock_r;
    end
  end

  assign src_core = wdt_mode_reg_r[SRC_BIT] & ~lock_r;
  assign rst_mode = wdt_mode_reg_r[RSTM_BIT] | lock_r;
  assign sel_eff  = wdt_mode_reg_r[SEL_LSB +: SEL_W];

  // Counting enable from the selected source
  assign cnt_tick = ~stopped_r & (src_core | internal_osc_clock);

  // Correct byte key restarts the interval
  assign key_ok = wr_acc & hit_key & lane0 & (pwdata[REG_W-1:0] == KEY_GOOD);

  // Forced overflow sources, suppressed while stopped
  always_comb begin
    forced = 1'b0;
    if (wr_acc && !stopped_r) begin
      if (hit_mode && lane0 && mode_written_r) begin
        forced = 1'b1;
      end else if (hit_key && lane0 && (pwdata[REG_W-1:0] != KEY_GOOD)) begin
        forced = 1'b1;
      end else if (hit_keybit) begin
        forced = 1'b1;
      end
    end
  end

  // Interval counter, cleared by a good key or a forced overflow
  wdk_counter #(
    .CNT_W (CNT_W),
    .SEL_W (SEL_W),
    .BASE  (INT_BASE)
  ) u_cnt (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (cnt_tick),
    .clr      (key_ok | forced),
    .sel      (sel_eff),
    .ovf      (cnt_ovf),
    .cnt      (cnt_val)
  );

  // Natural or forced overflow
  assign ovf_evt = cnt_ovf | forced;

  // Overflow action pulses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_r <= 1'b0;
    end else begin
      nmi_r <= ovf_evt & ~rst_mode;
    end
  end

  // Reset request pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstreq_r <= 1'b0;
    end else begin
      rstreq_r <= ovf_evt & rst_mode;
    end
  end

  // Status events raised this cycle
  always_comb begin
    stat_set = '0;
    stat_set[ST_NMI] = ovf_evt & ~rst_mode;
    stat_set[ST_RST] = ovf_evt & rst_mode;
    stat_set[ST_FORCED] = forced;
  end

  // Write-one-to-clear; a new event wins over the clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_acc && hit_stat) begin
      stat_nxt = stat_r & ~pwdata[STAT_W-1:0];
    end
    stat_nxt = stat_nxt | stat_set;
  end

  // Sticky status bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= STAT_RST_VAL;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Interrupt mask, byte lane 0 only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= MASK_RST_VAL;
    end else if (wr_acc && hit_mask && lane0) begin
      mask_r <= pwdata[STAT_W-1:0];
    end
  end

  // Level interrupt aligned with the status register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  // Ports driven straight from flip-flops
  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign wdt_overflow_nmi = nmi_r;
  assign wdt_reset_req    = rstreq_r;
  assign irq              = irq_r;

endmodule : wdk_top

`default_nettype wire

// file: common/wdk_pkg.sv
// Constants, register map and field layout of the watchdog key control block
`default_nettype none

package wdk_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          REG_W         = 8;

  // Register byte offsets
  localparam logic [7:0]  OFS_MODE      = 8'h00;
  localparam logic [7:0]  OFS_KEY       = 8'h04;
  localparam logic [7:0]  OFS_KEYBIT    = 8'h08;
  localparam logic [7:0]  OFS_STAT      = 8'h0C;
  localparam logic [7:0]  OFS_MASK      = 8'h10;
  localparam logic [7:0]  OFS_CNT       = 8'h14;

  // Key values
  localparam logic [7:0]  KEY_GOOD      = 8'hAC;
  localparam logic [7:0]  KEY_READ      = 8'h9A;

  // Mode register values and fields
  localparam logic [7:0]  MODE_STOP     = 8'h1F;
  localparam logic [7:0]  MODE_RST_VAL  = 8'h47;
  localparam logic [7:0]  MODE_WR_MASK  = 8'h5F;
  localparam int          SEL_LSB       = 0;
  localparam int          SEL_W         = 3;
  localparam int          SRC_BIT       = 3;
  localparam int          RSTM_BIT      = 6;

  // Interval counter: 2^(INT_BASE + sel) ticks
  localparam int          CNT_W         = 20;
  localparam int          INT_BASE      = 12;

  // Status / mask bits
  localparam int          STAT_W        = 3;
  localparam int          ST_NMI        = 0;
  localparam int          ST_RST        = 1;
  localparam int          ST_FORCED     = 2;
  localparam logic [2:0]  STAT_RST_VAL  = 3'h0;
  localparam logic [2:0]  MASK_RST_VAL  = 3'h0;

  // Internal oscillator tick divider default
  localparam int          OSC_DIV_DEF   = 4;

endpackage : wdk_pkg

`default_nettype wire

// file: verilog/wdk_counter.sv
// Watchdog interval counter with selectable power-of-two length
`default_nettype none

module wdk_counter #(
  parameter int CNT_W = 20,
  parameter int SEL_W = 3,
  parameter int BASE  = 12
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             clr,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  ovf,
  output logic [CNT_W-1:0]      cnt
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] lim;

  // Last count of a 2^(BASE+sel) tick interval
  always_comb begin
    lim = {CNT_W{1'b1}} >> (CNT_W - BASE - int'(sel));
  end

  assign ovf = tick & ~clr & (cnt_r == lim);
  assign cnt = cnt_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clr || ovf) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : wdk_counter

`default_nettype wire

// file: verification/wdk_top_monitor.sv
// Port-level checks for the watchdog key control block
`default_nettype none

module wdk_top_monitor (
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [wdk_pkg::ADDR_W-1:0] paddr,
  input wire logic [wdk_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [wdk_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       option_lock_bit,
  input wire logic                       wdt_overflow_nmi,
  input wire logic                       wdt_reset_req
);
  import wdk_pkg::*;

  logic seen_r;
  logic stop_r;
  logic first_r;
  logic lock_r;

  // Shadow of mode history and captured lock strap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r  <= 1'b0;
      stop_r  <= 1'b0;
      first_r <= 1'b1;
      lock_r  <= 1'b0;
    end else begin
      first_r <= 1'b0;
      if (first_r)
        lock_r <= option_lock_bit;
      if (psel && penable && pready && pwrite && paddr == OFS_MODE && pstrb[0]) begin
        seen_r <= 1'b1;
        if (!seen_r && pwdata[7:0] == MODE_STOP && !lock_r)
          stop_r <= 1'b1;
      end
    end
  end

  sequence s_wr(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  sequence s_ovf;
    wdt_reset_req || wdt_overflow_nmi;
  endsequence

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_mode_twice;
    s_wr(OFS_MODE) ##0 (pstrb[0] && seen_r && !stop_r) |=> s_ovf;
  endproperty
  a_mode_twice: assert property (p_mode_twice) else $error("mode rewrite gave no overflow");
  property p_bad_key;
    s_wr(OFS_KEY) ##0 (pstrb[0] && pwdata[7:0] != KEY_GOOD && !stop_r) |=> s_ovf;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key gave no overflow");
  property p_quiet;
    stop_r |-> !wdt_reset_req && !wdt_overflow_nmi;
  endproperty
  a_quiet: assert property (p_quiet) else $error("overflow while stopped");
  property p_keybit;
    s_wr(OFS_KEYBIT) ##0 !stop_r |=> s_ovf;
  endproperty
  a_keybit: assert property (p_keybit) else $error("bit access gave no overflow");
  property p_key_read;
    psel && penable && pready && !pwrite && (paddr == OFS_KEY || paddr == OFS_KEYBIT) |-> prdata == {24'h0, KEY_READ};
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read value wrong");
  property p_reset_mode;
    !seen_r |-> !wdt_overflow_nmi;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("interrupt before mode set");
  property p_lock_mode;
    lock_r |-> !wdt_overflow_nmi;
  endproperty
  a_lock_mode: assert property (p_lock_mode) else $error("interrupt while locked");
  property p_good_key;
    s_wr(OFS_KEY) ##0 (pstrb[0] && pwdata[7:0] == KEY_GOOD) |=> !(wdt_reset_req || wdt_overflow_nmi);
  endproperty
  a_good_key: assert property (p_good_key) else $error("good key gave overflow");
endmodule : wdk_top_monitor

bind wdk_top wdk_top_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .option_lock_bit(option_lock_bit), .wdt_overflow_nmi(wdt_overflow_nmi), .wdt_reset_req(wdt_reset_req));

`default_nettype wire

// file: verification/wdk_top_tb.sv
// Self-checking bench for the watchdog key control block
`default_nettype none

module wdk_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wdk_pkg::*;

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end

  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0]        pstrb = 4'hF;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              option_lock_bit = 1'b0;
  logic              wdt_overflow_nmi;
  logic              wdt_reset_req;
  logic              irq;
  logic [DATA_W-1:0] rd_v;
  logic [DATA_W-1:0] rd_w;
  logic              rd_e;
  int                n_mismatch = 0;
  int                cmp_count = 0;
  int                n_rst = 0;
  int                n_nmi = 0;

  wdk_top #(.OSC_DIV(2)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .option_lock_bit(option_lock_bit), .wdt_overflow_nmi(wdt_overflow_nmi),
    .wdt_reset_req(wdt_reset_req), .irq(irq));

  always #5 core_clk = ~core_clk;

  // Pulse tallies, read and zeroed by the scenarios
  always @(posedge core_clk) begin
    n_rst += int'(wdt_reset_req === 1'b1);
    n_nmi += int'(wdt_overflow_nmi === 1'b1);
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      summarize();
    end
    @(posedge core_clk);
  endtask : apb

  task automatic ovf(input int er, input int en);
    repeat (3) @(posedge core_clk);
    `CHK("reset pulses", er, n_rst)
    `CHK("nmi pulses", en, n_nmi)
    n_rst = 0;
    n_nmi = 0;
  endtask : ovf

  task automatic do_reset(input logic lk);
    rst_n <= 1'b0;
    option_lock_bit <= lk;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    n_rst = 0;
    n_nmi = 0;
  endtask : do_reset

  task automatic t_regs;
    apb(1'b0, OFS_MODE, '0);
    `CHK("mode", {24'h0, MODE_RST_VAL}, rd_v)
    apb(1'b0, OFS_KEYBIT, '0);
    `CHK("key read", {24'h0, KEY_READ}, rd_v)
    apb(1'b0, 8'h20, '0);
    `CHK("unmapped", 1'b1, rd_e)
  endtask : t_regs

  task automatic t_keys;
    apb(1'b1, OFS_KEY, 32'hAC);
    ovf(0, 0);
    apb(1'b1, OFS_MASK, 32'h6);
    apb(1'b1, OFS_KEY, 32'h55);
    ovf(1, 0);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, OFS_STAT, 32'h6);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, OFS_KEYBIT, 32'h1);
    ovf(1, 0);
  endtask : t_keys

  task automatic t_mode;
    int n;
    do_reset(1'b0);
    apb(1'b1, OFS_MODE, 32'h08);
    n = 0;
    while (wdt_overflow_nmi !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    if (wdt_overflow_nmi !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
    ovf(0, 1);
    apb(1'b1, OFS_MODE, 32'h08);
    ovf(0, 1);
    apb(1'b0, OFS_CNT, '0);
    `CHK("cnt", 16'h0, rd_v[19:4])
  endtask : t_mode

  task automatic t_stop;
    do_reset(1'b0);
    apb(1'b1, OFS_MODE, 32'h1F);
    apb(1'b0, OFS_CNT, '0);
    rd_w = rd_v;
    apb(1'b1, OFS_KEY, 32'h55);
    apb(1'b1, OFS_MODE, 32'h0);
    ovf(0, 0);
    apb(1'b0, OFS_CNT, '0);
    `CHK("stopped cnt", rd_w, rd_v)
  endtask : t_stop

  task automatic t_lock;
    do_reset(1'b1);
    apb(1'b1, OFS_MODE, 32'h1F);
    apb(1'b1, OFS_KEY, 32'h55);
    ovf(1, 0);
    do_reset(1'b1);
    apb(1'b1, OFS_MODE, 32'h08);
    apb(1'b0, OFS_CNT, '0);
    rd_w = rd_v;
    repeat (40) @(posedge core_clk);
    apb(1'b0, OFS_CNT, '0);
    `CHK("osc rate", 1'b1, (rd_v - rd_w) < 32)
    `CHK("osc ticks", 1'b1, (rd_v - rd_w) > 16)
    apb(1'b1, OFS_KEY, 32'h55);
    ovf(1, 0);
  endtask : t_lock

  initial begin
    do_reset(1'b0);
    t_regs();
    t_keys();
    t_mode();
    t_stop();
    t_lock();
    summarize();
  end
endmodule : wdk_top_tb

`default_nettype wire
